// ===== mmn_pkg.sv
/*
  Shared constants and types for the memory map and nonvolatile
  protection block: data-space windows, flash sections, lock layout,
  access spaces and programmer commands.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mmn_pkg;

  // Flash geometry in 16-bit words
  localparam int FL_AW = 16;
  localparam logic [15:0] BOOT_WORDS = 16'h1000;
  localparam logic [15:0] BOOT_LO = 16'hF000;
  localparam logic [15:0] TBL_LO = BOOT_LO - BOOT_WORDS;

  // Data-space windows
  localparam logic [15:0] EE_LO = 16'h1000;
  localparam logic [15:0] SR_LO = 16'h2000;
  localparam logic [15:0] SR_HI = 16'h3FFF;
  localparam logic [15:0] GP_N = 16'h0010;
  localparam logic [15:0] BIT_HI = 16'h001F;
  localparam logic [15:0] DIR_HI = 16'h003F;
  localparam int EE_AW = 12;
  localparam int SR_AW = 13;

  // Lock byte: two bits per section, one means unprogrammed
  localparam int LK_APP = 0;
  localparam int LK_TBL = 2;
  localparam int LK_BOOT = 4;
  localparam int LK_WR = 0;
  localparam int LK_RD = 1;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] FUSE_RST = 8'hFF;
  localparam logic [1:0] CFG_LOCK = 2'h3;

  // Calibration bytes pushed out of the factory row at reset
  localparam logic [3:0] CAL_N = 4'h4;

  // Opcode patterns of two-word instructions
  localparam logic [15:0] OPA_MASK = 16'hFC0F;
  localparam logic [15:0] OPA_VAL = 16'h9000;
  localparam logic [15:0] OPB_MASK = 16'hFE0C;
  localparam logic [15:0] OPB_VAL = 16'h940C;

  typedef enum logic [1:0] {
    SP_MAIN = 2'h0,
    SP_USIG = 2'h1,
    SP_PSIG = 2'h2,
    SP_CFG = 2'h3
  } mmn_space_e;

  typedef enum logic [1:0] {
    SEC_APP = 2'h0,
    SEC_TBL = 2'h1,
    SEC_BOOT = 2'h2
  } mmn_sect_e;

  typedef enum logic [1:0] {
    PC_READ = 2'h0,
    PC_WRITE = 2'h1,
    PC_UERASE = 2'h2,
    PC_CERASE = 2'h3
  } mmn_pcmd_e;

  typedef enum logic [1:0] {
    BO_NONE = 2'h0,
    BO_SET = 2'h1,
    BO_CLR = 2'h2,
    BO_TEST = 2'h3
  } mmn_bop_e;

endpackage : mmn_pkg

// ===== mmn_sect_chk.sv
/*
  Flash section classifier and lock check for one access.
  Assumes a lock byte laid out as in mmn_pkg, bits active low.
*/
`timescale 1ns/1ps
module mmn_sect_chk
  import mmn_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [15:0] pc,
  input wire logic [7:0] lock,
  output mmn_pkg::mmn_sect_e sect,
  output logic rd_ok,
  output logic wr_ok,
  output logic pc_boot
);

  // Table sits right under boot and spans the same size
  function automatic mmn_sect_e sect_of(input logic [15:0] a);
    if (a >= BOOT_LO) begin
      return SEC_BOOT;
    end else if (a >= TBL_LO) begin
      return SEC_TBL;
    end
    return SEC_APP;
  endfunction : sect_of

  logic [1:0] fld;

  // Per-section lock field decides read and write permission
  always_comb begin
    sect = sect_of(addr);
    pc_boot = (sect_of(pc) == SEC_BOOT);
    unique case (sect)
      SEC_TBL: fld = lock[LK_TBL +: 2];
      SEC_BOOT: fld = lock[LK_BOOT +: 2];
      default: fld = lock[LK_APP +: 2];
    endcase
    rd_ok = fld[LK_RD];
    wr_ok = fld[LK_WR];
  end

endmodule : mmn_sect_chk

// ===== mmn_mem_guard.sv
/*
  Memory map and nonvolatile protection: data-space decoder, flash
  access gate for CPU and programmer, lock and fuse storage, chip
  erase ordering, calibration push at reset and instruction fetch.
  Assumes flash, EEPROM, SRAM and I/O arrays answer reads in the
  same cycle, and FL_DONE pulses when a flash erase has finished.
*/
`timescale 1ns/1ps
module mmn_mem_guard
  import mmn_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire mmn_pkg::mmn_bop_e BIT_OP,
  input wire logic [2:0] BIT_SEL,
  output logic BIT_TST,
  input wire logic EE_MAP_EN,
  output logic [mmn_pkg::EE_AW-1:0] EE_ADDR,
  output logic [7:0] EE_WDATA,
  output logic EE_WR,
  output logic EE_RD,
  input wire logic [7:0] EE_RDATA,
  output logic [mmn_pkg::SR_AW-1:0] SR_ADDR,
  output logic [7:0] SR_WDATA,
  output logic SR_WR,
  output logic SR_RD,
  input wire logic [7:0] SR_RDATA,
  output logic [11:0] IO_ADDR,
  output logic [7:0] IO_WDATA,
  output logic IO_WR,
  output logic IO_RD,
  input wire logic [7:0] IO_RDATA,
  output logic IO_BSET,
  output logic IO_BCLR,
  input wire logic CF_REQ,
  input wire logic CF_WR,
  input wire logic [15:0] CF_PC,
  input wire logic [15:0] CF_ADDR,
  input wire mmn_pkg::mmn_space_e CF_SPACE,
  input wire logic [15:0] CF_WDATA,
  output logic [15:0] CF_RDATA,
  output logic CF_ACK,
  output logic CF_ERR,
  input wire logic PD_REQ,
  input wire mmn_pkg::mmn_pcmd_e PD_CMD,
  input wire logic [15:0] PD_ADDR,
  input wire mmn_pkg::mmn_space_e PD_SPACE,
  input wire logic [15:0] PD_WDATA,
  output logic [15:0] PD_RDATA,
  output logic PD_ACK,
  output logic PD_ERR,
  output logic [mmn_pkg::FL_AW-1:0] FL_ADDR,
  output logic [1:0] FL_SPACE,
  output logic [15:0] FL_WDATA,
  output logic FL_WR,
  output logic FL_RD,
  input wire logic [15:0] FL_RDATA,
  output logic FL_CERASE,
  output logic FL_UERASE,
  input wire logic FL_DONE,
  input wire logic [15:0] FETCH_PC,
  output logic [mmn_pkg::FL_AW-1:0] FETCH_ADDR,
  input wire logic [31:0] FETCH_WORDS,
  output logic [31:0] INSTR,
  output logic INSTR_LONG,
  output logic CAL_LD,
  output logic [3:0] CAL_SEL,
  output logic [7:0] CAL_DATA,
  output logic [7:0] LOCK_BITS,
  output logic [23:0] FUSE_BITS
);

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_IDLE = 3'h1,
    ST_CERASE = 3'h2,
    ST_LOCKCLR = 3'h3,
    ST_UERASE = 3'h4
  } mmn_state_e;

  typedef enum logic [1:0] {
    W_IO = 2'h0,
    W_EE = 2'h1,
    W_SR = 2'h2,
    W_NONE = 2'h3
  } mmn_win_e;

  typedef struct packed {
    mmn_state_e state;
    logic [15:0][7:0] gp;
    logic [7:0] rdata;
    logic bit_tst;
    logic [7:0] lock;
    logic [2:0][7:0] fuse;
    logic [3:0] cal_idx;
    logic cal_ld;
    logic [7:0] cal_data;
    logic [15:0] cf_rdata;
    logic cf_ack;
    logic cf_err;
    logic [15:0] pd_rdata;
    logic pd_ack;
    logic pd_err;
    logic [31:0] instr;
    logic ilong;
  } mmn_st_s;

  mmn_st_s cur_ff;
  mmn_st_s nxt_st;

  ////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // One flat map: fixed window starts, no banking
  function automatic mmn_win_e win_of(input logic [15:0] a,
                                      input logic ee_en);
    if (a < EE_LO) begin
      return W_IO;
    end else if (a < SR_LO) begin
      return ee_en ? W_EE : W_NONE;
    end else if (a <= SR_HI) begin
      return W_SR;
    end
    return W_NONE;
  endfunction : win_of

  // Two-word opcodes carry an address in the second word
  function automatic logic is_long(input logic [15:0] op);
    return ((op & OPA_MASK) == OPA_VAL) ||
           ((op & OPB_MASK) == OPB_VAL);
  endfunction : is_long

  ////////////////////////////////////////////////////////////////////
  // Flash grant: programmer first, CPU waits behind it

  logic g_val;
  logic g_cpu;
  logic g_wr;
  logic [15:0] g_addr;
  mmn_space_e g_space;
  logic [15:0] g_wdata;
  mmn_sect_e g_sect;
  logic g_rd_ok;
  logic g_wr_ok;
  logic g_pc_boot;
  logic g_wr_allow;
  mmn_win_e dwin;
  logic gp_hit;

  always_comb begin
    g_val = 1'b0;
    g_cpu = 1'b0;
    g_wr = 1'b0;
    g_addr = CF_ADDR;
    g_space = CF_SPACE;
    g_wdata = CF_WDATA;
    if (cur_ff.state == ST_INIT) begin
      g_val = 1'b1;
      g_addr = {12'h000, cur_ff.cal_idx};
      g_space = SP_PSIG;
    end else if (cur_ff.state == ST_IDLE && PD_REQ) begin
      g_val = (PD_CMD == PC_READ) || (PD_CMD == PC_WRITE);
      g_wr = (PD_CMD == PC_WRITE);
      g_addr = PD_ADDR;
      g_space = PD_SPACE;
      g_wdata = PD_WDATA;
    end else if (cur_ff.state == ST_IDLE && CF_REQ) begin
      g_val = 1'b1;
      g_cpu = 1'b1;
      g_wr = CF_WR;
    end
  end

  mmn_sect_chk u_chk (
    .addr(g_addr),
    .pc(CF_PC),
    .lock(cur_ff.lock),
    .sect(g_sect),
    .rd_ok(g_rd_ok),
    .wr_ok(g_wr_ok),
    .pc_boot(g_pc_boot)
  );

  // Whether a granted flash-array write may go ahead
  always_comb begin
    unique case (g_space)
      SP_MAIN: g_wr_allow = g_wr_ok && (!g_cpu || g_pc_boot);
      SP_USIG: g_wr_allow = !g_cpu || g_pc_boot;
      default: g_wr_allow = 1'b0;
    endcase
  end

  // Flash array strobes straight from the grant, erase strobes from the state
  assign FL_ADDR = g_addr;
  assign FL_SPACE = g_space;
  assign FL_WDATA = g_wdata;
  assign FL_WR = g_val && g_wr && g_wr_allow;
  assign FL_RD = g_val && !g_wr && (g_space != SP_CFG);
  assign FL_CERASE = (cur_ff.state == ST_CERASE);
  assign FL_UERASE = (cur_ff.state == ST_UERASE);
  assign FETCH_ADDR = FETCH_PC;

  ////////////////////////////////////////////////////////////////////
  // Data-space strobes to the arrays

  assign dwin = win_of(ADDR, EE_MAP_EN);
  assign gp_hit = (ADDR < GP_N);
  assign EE_ADDR = ADDR[EE_AW-1:0];
  assign EE_WDATA = WDATA;
  assign EE_WR = WR && (dwin == W_EE);
  assign EE_RD = RD && (dwin == W_EE);
  assign SR_ADDR = ADDR[SR_AW-1:0];
  assign SR_WDATA = WDATA;
  assign SR_WR = WR && (dwin == W_SR);
  assign SR_RD = RD && (dwin == W_SR);
  assign IO_ADDR = ADDR[11:0];
  assign IO_WDATA = WDATA;
  assign IO_WR = WR && (dwin == W_IO) && !gp_hit;
  // Bit test on external I/O reads the register in place
  assign IO_RD = (RD || BIT_OP == BO_TEST) && (dwin == W_IO) && !gp_hit;
  assign IO_BSET = (BIT_OP == BO_SET) && !gp_hit && ADDR <= BIT_HI;
  assign IO_BCLR = (BIT_OP == BO_CLR) && !gp_hit && ADDR <= BIT_HI;

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [15:0] rd_val;
    logic err;
    rd_val = 16'h0000;
    err = 1'b0;
    nxt_st = cur_ff;
    nxt_st.cal_ld = 1'b0;
    nxt_st.cf_ack = 1'b0;
    nxt_st.pd_ack = 1'b0;
    // Fetch path: two words registered, length from first word
    nxt_st.instr = FETCH_WORDS;
    nxt_st.ilong = is_long(FETCH_WORDS[15:0]);

    // Data-space write; holes swallow the write
    if (WR && dwin == W_IO && gp_hit) begin
      nxt_st.gp[ADDR[3:0]] = WDATA;
    end
    // Single-cycle bit set and clear on the low registers
    if (gp_hit && BIT_OP == BO_SET) begin
      nxt_st.gp[ADDR[3:0]][BIT_SEL] = 1'b1;
    end else if (gp_hit && BIT_OP == BO_CLR) begin
      nxt_st.gp[ADDR[3:0]][BIT_SEL] = 1'b0;
    end
    if (BIT_OP == BO_TEST) begin
      nxt_st.bit_tst = gp_hit ? cur_ff.gp[ADDR[3:0]][BIT_SEL]
                              : IO_RDATA[BIT_SEL];
    end
    // Read data: one cycle later, zero outside all windows
    if (RD) begin
      unique case (dwin)
        W_IO: nxt_st.rdata = gp_hit ? cur_ff.gp[ADDR[3:0]] : IO_RDATA;
        W_EE: nxt_st.rdata = EE_RDATA;
        W_SR: nxt_st.rdata = SR_RDATA;
        W_NONE: nxt_st.rdata = 8'h00;
      endcase
    end

    unique case (cur_ff.state)
      // Push factory calibration bytes before serving anyone
      ST_INIT: begin
        nxt_st.cal_ld = 1'b1;
        nxt_st.cal_data = FL_RDATA[7:0];
        nxt_st.cal_idx = cur_ff.cal_idx + 4'h1;
        if (cur_ff.cal_idx == CAL_N - 4'h1) begin
          nxt_st.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (PD_REQ && PD_CMD == PC_CERASE) begin
          nxt_st.state = ST_CERASE;
        end else if (PD_REQ && PD_CMD == PC_UERASE) begin
          nxt_st.state = ST_UERASE;
        end
      end
      // Flash content goes first so locks guard it to the end
      ST_CERASE: begin
        if (FL_DONE) begin
          nxt_st.state = ST_LOCKCLR;
        end
      end
      ST_LOCKCLR: begin
        nxt_st.lock = LOCK_RST;
        nxt_st.pd_ack = 1'b1;
        nxt_st.pd_err = 1'b0;
        nxt_st.state = ST_IDLE;
      end
      ST_UERASE: begin
        if (FL_DONE) begin
          nxt_st.pd_ack = 1'b1;
          nxt_st.pd_err = 1'b0;
          nxt_st.state = ST_IDLE;
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase

    // Granted flash access from CPU or programmer
    if (g_val && cur_ff.state == ST_IDLE) begin
      if (g_wr) begin
        if (g_space == SP_CFG && g_addr[1:0] == CFG_LOCK) begin
          // Programming only turns ones into zeros
          nxt_st.lock = cur_ff.lock & g_wdata[7:0];
        end else if (g_space == SP_CFG) begin
          if (g_cpu) begin
            err = 1'b1;
          end else begin
            nxt_st.fuse[g_addr[1:0]] = g_wdata[7:0];
          end
        end else begin
          err = !g_wr_allow;
        end
      end else begin
        unique case (g_space)
          SP_MAIN: begin
            rd_val = g_rd_ok ? FL_RDATA : 16'h0000;
            err = !g_rd_ok;
          end
          SP_CFG: begin
            rd_val = {8'h00, (g_addr[1:0] == CFG_LOCK) ?
                      cur_ff.lock : cur_ff.fuse[g_addr[1:0]]};
          end
          default: rd_val = FL_RDATA;
        endcase
      end
      if (g_cpu) begin
        nxt_st.cf_ack = 1'b1;
        nxt_st.cf_err = err;
        nxt_st.cf_rdata = rd_val;
      end else begin
        nxt_st.pd_ack = 1'b1;
        nxt_st.pd_err = err;
        nxt_st.pd_rdata = rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  // Locks and fuses come up unprogrammed, all ones
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cur_ff <= '0;
      cur_ff.state <= ST_INIT;
      cur_ff.lock <= LOCK_RST;
      cur_ff.fuse <= {FUSE_RST, FUSE_RST, FUSE_RST};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign RDATA = cur_ff.rdata;
  assign BIT_TST = cur_ff.bit_tst;
  assign CF_RDATA = cur_ff.cf_rdata;
  assign CF_ACK = cur_ff.cf_ack;
  assign CF_ERR = cur_ff.cf_err;
  assign PD_RDATA = cur_ff.pd_rdata;
  assign PD_ACK = cur_ff.pd_ack;
  assign PD_ERR = cur_ff.pd_err;
  assign INSTR = cur_ff.instr;
  assign INSTR_LONG = cur_ff.ilong;
  assign CAL_LD = cur_ff.cal_ld;
  assign CAL_SEL = cur_ff.cal_idx - 4'h1;
  assign CAL_DATA = cur_ff.cal_data;
  assign LOCK_BITS = cur_ff.lock;
  assign FUSE_BITS = cur_ff.fuse;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  spm_boot_only_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    FL_WR && g_cpu |-> g_pc_boot)
    else $error("flash write from CPU outside boot");

  lock_tighten_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    $past(cur_ff.state) != ST_LOCKCLR |->
    (cur_ff.lock & ~$past(cur_ff.lock)) == 8'h00)
    else $error("lock bit moved from programmed to unprogrammed");

  psig_no_write_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    FL_SPACE == SP_PSIG |-> !FL_WR)
    else $error("write reached factory row");

  lock_after_erase_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    cur_ff.state == ST_CERASE && FL_DONE |=>
    cur_ff.state == ST_LOCKCLR ##1 cur_ff.lock == LOCK_RST)
    else $error("locks not cleared after flash erase");

  fuse_cpu_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    g_val && g_cpu && g_wr && g_space == SP_CFG &&
    g_addr[1:0] != CFG_LOCK && cur_ff.state == ST_IDLE |=>
    $stable(cur_ff.fuse) && CF_ERR && CF_ACK)
    else $error("software changed a fuse");

  hole_read_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    RD && dwin == W_NONE |=> RDATA == 8'h00)
    else $error("unmapped read returned data");

  ee_window_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (EE_WR || EE_RD) |-> EE_MAP_EN && ADDR >= EE_LO && ADDR < SR_LO)
    else $error("EEPROM strobe outside mapped window");

  locked_read_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    g_val && g_cpu && !g_wr && g_space == SP_MAIN && !g_rd_ok &&
    cur_ff.state == ST_IDLE |=> CF_RDATA == 16'h0000 && CF_ERR)
    else $error("locked flash read leaked data");

  cal_count_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    $rose(cur_ff.state == ST_IDLE) && $past(cur_ff.state) == ST_INIT
    |-> CAL_LD && CAL_SEL == CAL_N - 4'h1)
    else $error("calibration push ended early");

endmodule : mmn_mem_guard

// ===== mmn_flash_model.sv
/*
  Behavioural flash array for the guard's far side: main flash, user
  row and a fixed factory row, same-cycle reads, fixed erase time.
  Assumes the guard holds an erase request until the done pulse.
*/
`timescale 1ns/1ps
module mmn_flash_model
  import mmn_pkg::*;
#(
  parameter int ERASE_CYC = 6
)
(
  input wire logic clk,
  input wire logic [mmn_pkg::FL_AW-1:0] fl_addr,
  input wire logic [1:0] fl_space,
  input wire logic [15:0] fl_wdata,
  input wire logic fl_wr,
  input wire logic fl_rd,
  output logic [15:0] fl_rdata,
  input wire logic fl_cerase,
  input wire logic fl_uerase,
  output logic fl_done
);
  logic [15:0] main_mem [0:65535];
  logic [15:0] usig [0:255];
  logic [15:0] word;
  logic [15:0] last_ff = 16'hFFFF;
  int cnt = 0;
  logic fresh = 1'b1;

  // Factory row is a fixed pattern with no write path
  always_comb begin
    case (fl_space)
      SP_MAIN: word = main_mem[fl_addr];
      SP_USIG: word = usig[fl_addr[7:0]];
      default: word = {8'h5A, 8'hA0 ^ fl_addr[7:0]};
    endcase
  end

  // Idle bus shows the inverse of the last word, never a stale copy
  assign fl_rdata = fl_rd ? word : ~last_ff;

  // Writes land at once; an erase takes ERASE_CYC cycles then pulses
  always @(posedge clk) begin
    // Cells start erased; filled at the first edge, still in reset
    fresh <= 1'b0;
    if (fresh) begin
      foreach (main_mem[i]) main_mem[i] <= 16'hFFFF;
      foreach (usig[i]) usig[i] <= 16'hFFFF;
    end
    if (fl_rd) last_ff <= word;
    if (fl_wr && fl_space == SP_MAIN) main_mem[fl_addr] <= fl_wdata;
    if (fl_wr && fl_space == SP_USIG) usig[fl_addr[7:0]] <= fl_wdata;
    fl_done <= 1'b0;
    if ((fl_cerase || fl_uerase) && !fl_done) begin
      cnt <= cnt + 1;
      if (cnt == ERASE_CYC - 1) begin
        cnt <= 0;
        fl_done <= 1'b1;
        if (fl_cerase) foreach (main_mem[i]) main_mem[i] <= 16'hFFFF;
        if (fl_uerase) foreach (usig[i]) usig[i] <= 16'hFFFF;
      end
    end
  end
endmodule : mmn_flash_model

// ===== mmn_mem_guard_tb_top.sv
/*
  Self-checking bench for the memory guard beside a flash model.
  Assumes the package, the design and the flash model compile first.
*/
`timescale 1ns/1ps
module mmn_mem_guard_tb_top;
  import mmn_pkg::*;
  logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, EE_MAP_EN = 1'b0;
  logic CF_REQ = 1'b0, CF_WR = 1'b0, PD_REQ = 1'b0;
  logic [2:0] BIT_SEL = 3'h0;
  logic [7:0] WDATA = 8'h0;
  logic [15:0] ADDR = 16'h0, CF_PC = 16'h0, CF_ADDR = 16'h0;
  logic [15:0] CF_WDATA = 16'h0, PD_ADDR = 16'h0, PD_WDATA = 16'h0;
  logic [15:0] FETCH_PC = 16'h0;
  logic [31:0] FETCH_WORDS = 32'h0;
  mmn_bop_e BIT_OP = BO_NONE;
  mmn_space_e CF_SPACE = SP_MAIN, PD_SPACE = SP_MAIN;
  mmn_pcmd_e PD_CMD = PC_READ;
  logic [15:0] CF_RDATA, PD_RDATA, FL_ADDR, FL_WDATA, FL_RDATA, FETCH_ADDR;
  logic [7:0] RDATA, EE_WDATA, EE_RDATA, SR_WDATA, SR_RDATA, IO_WDATA;
  logic [7:0] IO_RDATA, CAL_DATA, LOCK_BITS, lk_done;
  logic [11:0] EE_ADDR, IO_ADDR;
  logic [12:0] SR_ADDR;
  logic [1:0] FL_SPACE;
  logic [3:0] CAL_SEL;
  logic [23:0] FUSE_BITS;
  logic [31:0] INSTR;
  logic BIT_TST, EE_WR, EE_RD, SR_WR, SR_RD, IO_WR, IO_RD, IO_BSET, IO_BCLR;
  logic CF_ACK, CF_ERR, PD_ACK, PD_ERR, FL_WR, FL_RD, FL_CERASE, FL_UERASE;
  logic FL_DONE, INSTR_LONG, CAL_LD, bs, bc;
  logic [19:0] ee_seen;
  logic [20:0] sr_seen;
  int num_errors = 0, checks_done = 0, wr_n = 0, dw_n = 0, w0;

  mmn_mem_guard u_dut (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .BIT_OP, .BIT_SEL, .BIT_TST, .EE_MAP_EN, .EE_ADDR, .EE_WDATA, .EE_WR,
    .EE_RD, .EE_RDATA, .SR_ADDR, .SR_WDATA, .SR_WR, .SR_RD, .SR_RDATA,
    .IO_ADDR, .IO_WDATA, .IO_WR, .IO_RD, .IO_RDATA, .IO_BSET, .IO_BCLR,
    .CF_REQ, .CF_WR, .CF_PC, .CF_ADDR, .CF_SPACE, .CF_WDATA, .CF_RDATA,
    .CF_ACK, .CF_ERR, .PD_REQ, .PD_CMD, .PD_ADDR, .PD_SPACE, .PD_WDATA,
    .PD_RDATA, .PD_ACK, .PD_ERR, .FL_ADDR, .FL_SPACE, .FL_WDATA, .FL_WR,
    .FL_RD, .FL_RDATA, .FL_CERASE, .FL_UERASE, .FL_DONE, .FETCH_PC,
    .FETCH_ADDR, .FETCH_WORDS, .INSTR, .INSTR_LONG, .CAL_LD, .CAL_SEL,
    .CAL_DATA, .LOCK_BITS, .FUSE_BITS);
  mmn_flash_model u_fl (.clk(CLK), .fl_addr(FL_ADDR), .fl_space(FL_SPACE),
    .fl_wdata(FL_WDATA), .fl_wr(FL_WR), .fl_rd(FL_RD), .fl_rdata(FL_RDATA),
    .fl_cerase(FL_CERASE), .fl_uerase(FL_UERASE), .fl_done(FL_DONE));

  always #2.5 CLK = ~CLK;
  // Byte arrays answer with address patterns; idle buses show the inverse
  assign SR_RDATA = SR_RD ? SR_ADDR[7:0] ^ 8'h3C : ~SR_ADDR[7:0];
  assign EE_RDATA = EE_RD ? EE_ADDR[7:0] ^ 8'h69 : ~EE_ADDR[7:0];
  assign IO_RDATA = IO_RD ? IO_ADDR[7:0] ^ 8'hC5 : ~IO_ADDR[7:0];
  // Write counts, and the lock byte seen as the erase finishes
  always @(posedge CLK) begin
    if (FL_WR === 1'b1) wr_n <= wr_n + 1;
    if ((SR_WR | EE_WR | IO_WR) === 1'b1) dw_n <= dw_n + 1;
    if (FL_DONE === 1'b1) lk_done <= LOCK_BITS;
    if (EE_WR === 1'b1) ee_seen <= {EE_ADDR, EE_WDATA};
    if (SR_WR === 1'b1) sr_seen <= {SR_ADDR, SR_WDATA};
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // One-cycle strobes; read data checked in the cycle after only
  task automatic dwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : dwr
  task automatic drd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask : drd
  task automatic bop(input mmn_bop_e op, input logic [15:0] a,
    input logic [2:0] s);
    @(posedge CLK);
    BIT_OP <= op;
    ADDR <= a;
    BIT_SEL <= s;
    #1;
    bs = IO_BSET;
    bc = IO_BCLR;
    @(posedge CLK);
    BIT_OP <= BO_NONE;
    #1;
  endtask : bop
  // Request held until its ack, dropped in the ack cycle
  task automatic fo(input logic pd, input mmn_pcmd_e c,
    input logic [15:0] pc, input mmn_space_e sp, input logic [15:0] a, wd,
    input logic ee, input logic [15:0] ed);
    int i;
    logic [15:0] rd;
    logic er;
    @(posedge CLK);
    if (pd) begin
      PD_REQ <= 1'b1;
      PD_CMD <= c;
      PD_SPACE <= sp;
      PD_ADDR <= a;
      PD_WDATA <= wd;
    end else begin
      CF_REQ <= 1'b1;
      CF_WR <= c == PC_WRITE;
      CF_PC <= pc;
      CF_SPACE <= sp;
      CF_ADDR <= a;
      CF_WDATA <= wd;
    end
    for (i = 0; i < 60; i++) begin
      @(posedge CLK);
      #1;
      if ((pd ? PD_ACK : CF_ACK) === 1'b1) break;
    end
    rd = pd ? PD_RDATA : CF_RDATA;
    er = pd ? PD_ERR : CF_ERR;
    PD_REQ <= 1'b0;
    CF_REQ <= 1'b0;
    chk(i < 60, 1'b1);
    chk(er, ee);
    if (c == PC_READ) chk(sp == SP_CFG ? rd[7:0] : rd, ed);
  endtask : fo

  ////////////////////////////////////////////////////////////////////////
  task automatic t_cal;
    int n = 0;
    chk({LOCK_BITS, FUSE_BITS}, 32'hFFFFFFFF);
    repeat (6) begin
      @(posedge CLK);
      #1;
      if (CAL_LD === 1'b1) begin
        chk({CAL_SEL, CAL_DATA}, {n[3:0], 8'hA0 ^ n[7:0]});
        n++;
      end
    end
    chk(n, 4);
  endtask : t_cal
  task automatic t_decode;
    drd(16'h2005, 8'h05 ^ 8'h3C);
    drd(16'h3FFF, 8'hFF ^ 8'h3C);
    drd(16'h0FFF, 8'hFF ^ 8'hC5);
    drd(16'h1004, 8'h00);
    drd(16'h4000, 8'h00);
    w0 = dw_n;
    dwr(16'h1800, 8'h11);
    dwr(16'h4000, 8'h22);
    EE_MAP_EN <= 1'b1;
    drd(16'h1004, 8'h04 ^ 8'h69);
    dwr(16'h1FFF, 8'h33);
    @(posedge CLK);
    chk(dw_n, w0 + 1);
    chk(ee_seen, {12'hFFF, 8'h33});
    dwr(16'h2ABC, 8'h44);
    @(posedge CLK);
    chk(sr_seen, {13'h0ABC, 8'h44});
    dwr(16'h0003, 8'hA5);
    drd(16'h0003, 8'hA5);
  endtask : t_decode
  task automatic t_bits;
    bop(BO_SET, 16'h0003, 3'h6);
    drd(16'h0003, 8'hE5);
    bop(BO_TEST, 16'h0003, 3'h5);
    chk(BIT_TST, 1'b1);
    bop(BO_CLR, 16'h0003, 3'h7);
    drd(16'h0003, 8'h65);
    bop(BO_SET, 16'h001F, 3'h1);
    chk(bs, 1'b1);
    bop(BO_CLR, 16'h0020, 3'h1);
    chk(bc, 1'b0);
  endtask : t_bits
  task automatic t_fetch(input logic [31:0] w, input logic lg);
    @(posedge CLK);
    FETCH_PC <= w[31:16];
    FETCH_WORDS <= w;
    @(posedge CLK);
    #1;
    chk(FETCH_ADDR, w[31:16]);
    chk({INSTR_LONG, INSTR[15:0]}, {lg, w[15:0]});
    if (lg) chk(INSTR[31:16], w[31:16]);
  endtask : t_fetch
  task automatic t_spm;
    w0 = wr_n;
    fo(0, PC_WRITE, 16'h1000, SP_MAIN, 16'h0100, 16'h1111, 1, 0);
    fo(0, PC_WRITE, 16'hEFFF, SP_MAIN, 16'h0100, 16'h1111, 1, 0);
    chk(wr_n, w0);
    fo(0, PC_WRITE, 16'hF000, SP_MAIN, 16'hF200, 16'hBEEF, 0, 0);
    fo(1, PC_WRITE, 16'h0, SP_MAIN, 16'h0200, 16'h1357, 0, 0);
    fo(0, PC_READ, 16'h0, SP_MAIN, 16'h0200, 16'h0, 0, 16'h1357);
    fo(1, PC_READ, 16'h0, SP_MAIN, 16'hF200, 16'h0, 0, 16'hBEEF);
    w0 = wr_n;
    fo(1, PC_WRITE, 16'h0, SP_PSIG, 16'h0001, 16'h0, 1, 0);
    chk(wr_n, w0);
    fo(1, PC_READ, 16'h0, SP_PSIG, 16'h0002, 16'h0, 0, 16'h5AA2);
    fo(0, PC_READ, 16'h0, SP_PSIG, 16'h0003, 16'h0, 0, 16'h5AA3);
    fo(1, PC_WRITE, 16'h0, SP_USIG, 16'h0005, 16'hA55A, 0, 0);
    fo(0, PC_READ, 16'h0, SP_USIG, 16'h0005, 16'h0, 0, 16'hA55A);
    fo(0, PC_WRITE, 16'hF100, SP_USIG, 16'h0006, 16'h0F0F, 0, 0);
    fo(1, PC_READ, 16'h0, SP_USIG, 16'h0006, 16'h0, 0, 16'h0F0F);
  endtask : t_spm
  task automatic t_fuse_lock;
    fo(0, PC_WRITE, 16'hF100, SP_CFG, 16'h0000, 16'h0000, 1, 0);
    fo(1, PC_WRITE, 16'h0, SP_CFG, 16'h0001, 16'h007E, 0, 0);
    chk(FUSE_BITS, 24'hFF7EFF);
    fo(0, PC_READ, 16'h0, SP_CFG, 16'h0001, 16'h0, 0, 16'h007E);
    fo(1, PC_WRITE, 16'h0, SP_CFG, 16'h0003, 16'h00F6, 0, 0);
    fo(1, PC_WRITE, 16'h0, SP_CFG, 16'h0003, 16'h00FF, 0, 0);
    chk(LOCK_BITS, 8'hF6);
    w0 = wr_n;
    fo(0, PC_WRITE, 16'hF000, SP_MAIN, 16'h0300, 16'h2222, 1, 0);
    fo(1, PC_WRITE, 16'h0, SP_MAIN, 16'hEFFF, 16'h3333, 0, 0);
    chk(wr_n, w0 + 1);
    fo(0, PC_READ, 16'h0, SP_MAIN, 16'hE000, 16'h0, 1, 16'h0);
    fo(0, PC_READ, 16'h0, SP_MAIN, 16'hDFFF, 16'h0, 0, 16'hFFFF);
    fo(1, PC_CERASE, 16'h0, SP_MAIN, 16'h0, 16'h0, 0, 0);
    chk({lk_done, LOCK_BITS}, 16'hF6FF);
    fo(1, PC_READ, 16'h0, SP_MAIN, 16'hF200, 16'h0, 0, 16'hFFFF);
    fo(1, PC_READ, 16'h0, SP_USIG, 16'h0005, 16'h0, 0, 16'hA55A);
    fo(1, PC_UERASE, 16'h0, SP_USIG, 16'h0, 16'h0, 0, 0);
    fo(1, PC_READ, 16'h0, SP_USIG, 16'h0005, 16'h0, 0, 16'hFFFF);
  endtask : t_fuse_lock

  ////////////////////////////////////////////////////////////////////////
  // Reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    t_cal();
    t_decode();
    t_bits();
    t_fetch({16'h1234, 16'h940C}, 1'b1);
    t_fetch({16'hABCD, 16'h9100}, 1'b1);
    t_fetch({16'h5678, 16'h9408}, 1'b0);
    t_spm();
    t_fuse_lock();
    final_report();
  end
  // Watchdog far beyond the 130 or so cycles the run needs
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule : mmn_mem_guard_tb_top
